// ---- logic/cbd_pkg.sv ----
package cbd_pkg;
    // address field layout
    localparam int ADDR_W = 32;
    localparam int PAGE_LO = 13;
    localparam int PAGE_HI = 31;
    localparam int PAGE_W = PAGE_HI - PAGE_LO + 1;
    localparam int CIDX_W = 16;
    localparam int TAG_LO = 5;
    localparam int TAG_HI = 15;
    localparam int TAG_W = TAG_HI - TAG_LO + 1;
    localparam int ASI_W = 8;
    localparam int HALF_W = 32;
    // control data and address bus fields
    localparam int CHK_W = 9;
    localparam int DIAG_W = 8;
    localparam int IRQ_W = 16;
    localparam int DEC_W = 8;
    // space identifier bits
    localparam int ASI_SUPER_BIT = 0;
    localparam int ASI_DATA_BIT = 1;
    localparam int ASI_ST3_BIT = 3;
    localparam int ASI_ST4_BIT = 4;
    localparam int ASI_ST5_BIT = 5;
    localparam logic [ASI_W-1:0] ASI_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    // translation capacity: 16 Mbyte split into two spaces
    localparam longint XLATE_MAP_BYTES = 64'h0000_0000_0100_0000;
    localparam longint XLATE_SPACE_BYTES = XLATE_MAP_BYTES / 2;
    localparam int XLATE_ENTRIES = 1024;
    // cache: two banks of 32 Kbyte words
    localparam int BANK_BYTES = 32768;
    localparam int BANK_WORDS = BANK_BYTES / 4;
    localparam int BANK_AW = 13;
    // rates: 64 bits each 50 ns in, 32 bits each 60 ns out at 10 ns clock
    localparam int CLK_NS = 10;
    localparam int FILL_NS = 50;
    localparam int READ_NS = 60;
    localparam int FILL_CYC = FILL_NS / CLK_NS;
    localparam int READ_CYC = READ_NS / CLK_NS;
    localparam logic [3:0] FILL_CNT = 4'(FILL_CYC - 1);
    localparam logic [3:0] READ_CNT = 4'(READ_CYC - 1);
    // phase generator: 12 phases of 30 degrees
    localparam int PHASE_DEG = 30;
    localparam int PHASES = 360 / PHASE_DEG;
    localparam logic [3:0] PHASE_LAST = 4'(PHASES - 1);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ASI_W-1:0] asi;
        logic valid;
        logic write;
    } cbd_req_s;

    typedef struct packed {
        logic [HALF_W-1:0] high;
        logic [HALF_W-1:0] low;
    } cbd_line_s;

    typedef struct packed {
        logic [CHK_W-1:0] checkByte;
        logic [DIAG_W-1:0] diagAddr;
        logic [IRQ_W-1:0] irqInfo;
        logic [DEC_W-1:0] irqDecode;
    } cbd_route_s;
endpackage : cbd_pkg

// ---- logic/cbd_xlate_ram.sv ----
`timescale 1ns/1ps
// translation store: page frame plus page tag and flags per entry
module cbd_xlate_ram #(
    parameter int ENTRIES = cbd_pkg::XLATE_ENTRIES,
    parameter int IDX_W = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // lookup
    input wire logic [IDX_W-1:0] lookIdx,
    input wire logic [cbd_pkg::PAGE_W-1:0] lookTag,
    output logic [cbd_pkg::PAGE_W-1:0] lookFrame,
    output logic lookHit,
    output logic lookWrOk,
    output logic lookUserOk,
    // software load
    input wire logic loadEn,
    input wire logic [IDX_W-1:0] loadIdx,
    input wire logic [cbd_pkg::PAGE_W-1:0] loadTag,
    input wire logic [cbd_pkg::PAGE_W-1:0] loadFrame,
    input wire logic [2:0] loadFlags
);
    import cbd_pkg::*;

    logic [PAGE_W-1:0] frameMem [ENTRIES];
    logic [PAGE_W-1:0] tagMem [ENTRIES];
    logic [2:0] flagMem [ENTRIES];
    logic [ENTRIES-1:0] valid_q;
    logic [ENTRIES-1:0] valid_d;

    always_comb begin
        valid_d = valid_q;
        if (loadEn) begin
            valid_d[loadIdx] = loadFlags[0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            valid_q <= '0;
        end else begin
            valid_q <= valid_d;
        end
    end

    // storage arrays carry no reset; valid bits guard them
    always_ff @(posedge ref_clk) begin
        if (loadEn) begin
            frameMem[loadIdx] <= loadFrame;
            tagMem[loadIdx] <= loadTag;
            flagMem[loadIdx] <= loadFlags;
        end
    end

    always_comb begin
        lookFrame = frameMem[lookIdx];
        lookHit = valid_q[lookIdx] && (tagMem[lookIdx] == lookTag);
        lookWrOk = flagMem[lookIdx][1];
        lookUserOk = flagMem[lookIdx][2];
    end
endmodule : cbd_xlate_ram

// ---- logic/cbd_datapath.sv ----
`timescale 1ns/1ps
// Contract
// R01 - physical address: upper 19 bits translated, low 13 passed through
// R02 - tag comparators flag a match when translated page equals stored tag
// R03 - physical match compares stored tag against physical bits 31:13 only
// R04 - physical address registered, registers drive control address bus
// R05 - registered 8-bit space identifier given to tag and launcher logic
// R06 - launcher control uses identifier bits 3, 4 and 5 as status
// R07 - tag logic decodes identifier into two virtual hit enables
// R08 - 64-bit cache data carried as high and low 32-bit halves
// R09 - check byte taken from lowest nine control data bits
// R10 - diagnostic RAM read drives only lowest control data byte; code drives all 32 bits, upper 24 as zero
// R11 - interrupt serial info taken from lower two control data bytes
// R12 - interrupt decoders use lower eight control address bits
// R13 - on hold command, low 16 address bits go to cache index bus
// R14 - on hold command, upper address bytes go to translation index
// R15 - translation index bits 15:13 come from cache index top bits
// R16 - watcher tag access uses watcher address for tag RAM address
// R17 - watcher tag address also addresses the identification EEPROM
// R18 - translation maps 16 Mbyte, half data space, half instruction space
// R19 - missing translation reported; walk helped by index and base registers
// R20 - cache built as even and odd 32 Kbyte banks filled together
// R21 - fill 64 bits each 50 ns, deliver 32 bits each 60 ns
// R22 - write and user protection violations reported as faults
// R23 - clocks derived from one source as phases 30 degrees apart
// R24 - pipeline and identifier registers on one phase, loaded by hold
module cbd_datapath #(
    parameter int XLATE_IDX_W = 10,
    parameter logic [cbd_pkg::ADDR_W-1:0] DIR_BASE_RST = cbd_pkg::ADDR_RST
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // processor side
    input wire cbd_pkg::cbd_req_s procReq,
    input wire logic holdLoad,
    output logic procFault,
    output logic xlateMiss,
    output logic [cbd_pkg::HALF_W-1:0] procRdData,
    output logic procRdValid,
    // translation load and walk assist
    input wire logic walkLoad,
    input wire logic [cbd_pkg::PAGE_W-1:0] walkFrame,
    input wire logic [2:0] walkFlags,
    input wire logic dirBaseWr,
    input wire logic [cbd_pkg::ADDR_W-1:0] dirBaseData,
    output logic [cbd_pkg::ADDR_W-1:0] dirBase,
    output logic [XLATE_IDX_W-1:0] walkIndex,
    // addresses
    output logic [cbd_pkg::ADDR_W-1:0] phys_addr_bus,
    output logic [cbd_pkg::CIDX_W-1:0] cache_index_bus,
    output logic [cbd_pkg::ADDR_W-1:0] xlate_index_bus,
    output logic [cbd_pkg::TAG_W-1:0] tag_ram_addr,
    output logic [cbd_pkg::ADDR_W-1:0] ctrl_addr_bus,
    output logic [cbd_pkg::ASI_W-1:0] latched_space_id,
    // tag compare
    input wire logic [cbd_pkg::PAGE_W-1:0] storedPhysTag,
    output logic phys_tag_match,
    output logic [1:0] virtHitEn,
    output logic [2:0] launchStatus,
    // watcher
    input wire logic watcherTagAccess,
    input wire logic idRomAccess,
    input wire logic [cbd_pkg::CIDX_W-1:0] watcher_tag_addr,
    output logic [cbd_pkg::CIDX_W-1:0] idRomAddr,
    output logic idRomSel,
    // cache line fill from system side
    input wire cbd_pkg::cbd_line_s fillLine,
    input wire logic fillValid,
    output logic fillReady,
    // control data routing
    input wire logic [cbd_pkg::ADDR_W-1:0] ctrl_data_bus,
    input wire logic [cbd_pkg::DIAG_W-1:0] diagRdData,
    input wire logic diagRd,
    output logic [cbd_pkg::ADDR_W-1:0] ctrlDataDrive,
    output logic ctrlDataOe,
    output cbd_pkg::cbd_route_s route,
    // board phases
    output logic [cbd_pkg::PHASES-1:0] phaseEn
);
    import cbd_pkg::*;

    function automatic logic [1:0] hitEnables(input logic [ASI_W-1:0] asi);
        hitEnables = {asi[ASI_DATA_BIT] & ~asi[ASI_ST4_BIT],
                      ~asi[ASI_DATA_BIT] & ~asi[ASI_ST5_BIT]};
    endfunction : hitEnables

    // phase generator
    logic [3:0] phase_q;
    logic [3:0] phase_d;
    // pipeline
    logic [ADDR_W-1:0] pipeAddr_q;
    logic [ADDR_W-1:0] pipeAddr_d;
    logic [ASI_W-1:0] asi_q;
    logic [ASI_W-1:0] asi_d;
    logic pipeWr_q;
    logic pipeWr_d;
    logic pipeValid_q;
    logic pipeValid_d;
    logic [ADDR_W-1:0] ctrlAddr_q;
    logic [ADDR_W-1:0] ctrlAddr_d;
    logic [ADDR_W-1:0] dirBase_q;
    logic [ADDR_W-1:0] dirBase_d;
    logic [XLATE_IDX_W-1:0] walkIdx_q;
    logic [XLATE_IDX_W-1:0] walkIdx_d;
    logic fault_q;
    logic fault_d;
    logic miss_q;
    logic miss_d;
    logic phys_tag_match_q;
    logic phys_tag_match_d;
    // cache banks
    logic [HALF_W-1:0] evenBank [BANK_WORDS];
    logic [HALF_W-1:0] oddBank [BANK_WORDS];
    logic [3:0] fillCnt_q;
    logic [3:0] fillCnt_d;
    logic [3:0] readCnt_q;
    logic [3:0] readCnt_d;
    logic [HALF_W-1:0] rdData_q;
    logic [HALF_W-1:0] rdData_d;
    logic rdValid_q;
    logic rdValid_d;
    // translation lookup
    logic [PAGE_W-1:0] lookFrame;
    logic lookHit;
    logic lookWrOk;
    logic lookUserOk;
    logic [XLATE_IDX_W-1:0] lookIdx;
    logic [BANK_AW-1:0] bankIdx;
    logic doFill;

    typedef enum logic [1:0] {
        CBD_IDLE = 2'b00,
        CBD_XLATE = 2'b01,
        CBD_READ = 2'b10
    } cbd_state_e;
    cbd_state_e state_q;
    cbd_state_e state_d;

    always_comb begin
        phase_d = (phase_q == PHASE_LAST) ? 4'h0 : phase_q + 4'h1; // R23
    end

    always_comb begin
        for (int i = 0; i < PHASES; i++) begin
            phaseEn[i] = (phase_q == 4'(i)); // R23
        end
    end

    // the space bit picks the data or instruction half of the map
    assign lookIdx = {asi_q[ASI_DATA_BIT],
                      pipeAddr_q[PAGE_LO +: XLATE_IDX_W-1]}; // R18

    cbd_xlate_ram #(
        .ENTRIES(1 << XLATE_IDX_W),
        .IDX_W(XLATE_IDX_W)
    ) u_xlate (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .lookIdx(lookIdx),
        .lookTag(pipeAddr_q[PAGE_HI:PAGE_LO]),
        .lookFrame(lookFrame),
        .lookHit(lookHit),
        .lookWrOk(lookWrOk),
        .lookUserOk(lookUserOk),
        .loadEn(walkLoad),
        .loadIdx(walkIdx_q),
        .loadTag(pipeAddr_q[PAGE_HI:PAGE_LO]),
        .loadFrame(walkFrame),
        .loadFlags(walkFlags)
    );

    always_comb begin
        state_d = state_q;
        pipeAddr_d = pipeAddr_q;
        asi_d = asi_q;
        pipeWr_d = pipeWr_q;
        pipeValid_d = 1'b0;
        ctrlAddr_d = ctrlAddr_q;
        fault_d = 1'b0;
        miss_d = miss_q;
        phys_tag_match_d = phys_tag_match_q;
        walkIdx_d = walkIdx_q;
        dirBase_d = dirBaseWr ? dirBaseData : dirBase_q; // R19
        if (walkLoad) begin
            walkIdx_d = walkIdx_q + 1'b1; // R19
        end
        case (state_q)
            CBD_IDLE: begin
                // hold command loads only on phase 0 of the board cycle
                if (holdLoad && procReq.valid && phaseEn[0]) begin // R24
                    pipeAddr_d = procReq.addr; // R13 R14
                    asi_d = procReq.asi; // R05
                    pipeWr_d = procReq.write;
                    state_d = CBD_XLATE;
                end
            end
            CBD_XLATE: begin
                if (!lookHit) begin
                    miss_d = 1'b1; // R19
                    walkIdx_d = lookIdx;
                    state_d = CBD_IDLE;
                end else if ((pipeWr_q && !lookWrOk) ||
                             (!asi_q[ASI_SUPER_BIT] && !lookUserOk)) begin
                    fault_d = 1'b1; // R22
                    state_d = CBD_IDLE;
                end else begin
                    miss_d = 1'b0;
                    ctrlAddr_d = {lookFrame, pipeAddr_q[PAGE_LO-1:0]}; // R01 R04
                    phys_tag_match_d = (storedPhysTag == lookFrame); // R02 R03
                    pipeValid_d = 1'b1;
                    state_d = CBD_READ;
                end
            end
            CBD_READ: begin
                if (readCnt_q == 4'h0) begin
                    state_d = CBD_IDLE;
                end
            end
            default: begin
                state_d = CBD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 4'h0;
            state_q <= CBD_IDLE;
            pipeAddr_q <= ADDR_RST;
            asi_q <= ASI_RST;
            pipeWr_q <= 1'b0;
            pipeValid_q <= 1'b0;
            ctrlAddr_q <= ADDR_RST;
            dirBase_q <= DIR_BASE_RST;
            walkIdx_q <= '0;
            fault_q <= 1'b0;
            miss_q <= 1'b0;
            phys_tag_match_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            state_q <= state_d;
            pipeAddr_q <= pipeAddr_d;
            asi_q <= asi_d;
            pipeWr_q <= pipeWr_d;
            pipeValid_q <= pipeValid_d;
            ctrlAddr_q <= ctrlAddr_d;
            dirBase_q <= dirBase_d;
            walkIdx_q <= walkIdx_d;
            fault_q <= fault_d;
            miss_q <= miss_d;
            phys_tag_match_q <= phys_tag_match_d;
        end
    end

    // cache: one index addresses both banks; a fill writes both halves at once
    assign bankIdx = ctrlAddr_q[3 +: BANK_AW];
    assign fillReady = (fillCnt_q == 4'h0); // R21
    assign doFill = fillValid && fillReady;

    always_comb begin
        fillCnt_d = doFill ? FILL_CNT : // R21
                    ((fillCnt_q == 4'h0) ? 4'h0 : fillCnt_q - 4'h1);
        readCnt_d = (readCnt_q == 4'h0) ? 4'h0 : readCnt_q - 4'h1;
        rdValid_d = 1'b0;
        rdData_d = rdData_q;
        if (pipeValid_q) begin
            readCnt_d = READ_CNT; // R21
            // address bit 2 selects the odd bank
            rdData_d = ctrlAddr_q[2] ? oddBank[bankIdx] : evenBank[bankIdx]; // R20
            rdValid_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (doFill) begin
            evenBank[bankIdx] <= fillLine.low; // R08 R20
            oddBank[bankIdx] <= fillLine.high; // R08 R20
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fillCnt_q <= 4'h0;
            readCnt_q <= 4'h0;
            rdData_q <= '0;
            rdValid_q <= 1'b0;
        end else begin
            fillCnt_q <= fillCnt_d;
            readCnt_q <= readCnt_d;
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    // address fan-out
    always_comb begin
        phys_addr_bus = {lookFrame, pipeAddr_q[PAGE_LO-1:0]}; // R01
        cache_index_bus = pipeAddr_q[CIDX_W-1:0]; // R13
        xlate_index_bus = {pipeAddr_q[ADDR_W-1:CIDX_W],
                           cache_index_bus[CIDX_W-1:PAGE_LO],
                           pipeAddr_q[PAGE_LO-1:0]}; // R14 R15
        tag_ram_addr = watcherTagAccess ? watcher_tag_addr[TAG_HI:TAG_LO]
                                        : pipeAddr_q[TAG_HI:TAG_LO]; // R16
        idRomAddr = watcher_tag_addr; // R17
        idRomSel = idRomAccess; // R17
        ctrl_addr_bus = ctrlAddr_q; // R04
        latched_space_id = asi_q; // R05
        phys_tag_match = phys_tag_match_q; // R02
        virtHitEn = hitEnables(asi_q); // R07
        launchStatus = {asi_q[ASI_ST5_BIT], asi_q[ASI_ST4_BIT],
                        asi_q[ASI_ST3_BIT]}; // R06
        procFault = fault_q;
        xlateMiss = miss_q;
        dirBase = dirBase_q;
        walkIndex = walkIdx_q;
        procRdData = rdData_q;
        procRdValid = rdValid_q;
    end

    // control data routing; the whole word is driven on diagnostic reads, upper bytes as zero
    always_comb begin
        ctrlDataDrive = {{(ADDR_W-DIAG_W){1'b0}}, diagRdData}; // R10
        ctrlDataOe = diagRd; // R10
        route.checkByte = ctrl_data_bus[CHK_W-1:0]; // R09
        route.irqInfo = ctrl_data_bus[IRQ_W-1:0]; // R11
        route.irqDecode = ctrlAddr_q[DEC_W-1:0]; // R12
        route.diagAddr = ctrlAddr_q[DIAG_W-1:0];
    end
endmodule : cbd_datapath

// ---- tb/cbd_datapath_sva.sv ----
`timescale 1ns/1ps
module cbd_datapath_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // watched ports
    input wire cbd_pkg::cbd_req_s procReq,
    input wire logic holdLoad,
    input wire logic [cbd_pkg::ADDR_W-1:0] phys_addr_bus,
    input wire logic [cbd_pkg::CIDX_W-1:0] cache_index_bus,
    input wire logic [cbd_pkg::ADDR_W-1:0] xlate_index_bus,
    input wire logic [cbd_pkg::TAG_W-1:0] tag_ram_addr,
    input wire logic [cbd_pkg::ADDR_W-1:0] ctrl_addr_bus,
    input wire logic [cbd_pkg::ASI_W-1:0] latched_space_id,
    input wire logic [1:0] virtHitEn,
    input wire logic [2:0] launchStatus,
    input wire logic watcherTagAccess,
    input wire logic idRomAccess,
    input wire logic [cbd_pkg::CIDX_W-1:0] watcher_tag_addr,
    input wire logic [cbd_pkg::CIDX_W-1:0] idRomAddr,
    input wire logic idRomSel,
    input wire logic fillValid,
    input wire logic fillReady,
    input wire logic [cbd_pkg::ADDR_W-1:0] ctrl_data_bus,
    input wire logic [cbd_pkg::DIAG_W-1:0] diagRdData,
    input wire logic diagRd,
    input wire logic [cbd_pkg::ADDR_W-1:0] ctrlDataDrive,
    input wire logic ctrlDataOe,
    input wire cbd_pkg::cbd_route_s route,
    input wire logic [cbd_pkg::PHASES-1:0] phaseEn
);
    import cbd_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_phase_hot; $onehot(phaseEn); endproperty
    a_phase_hot: assert property (p_phase_hot) else $error("phase not one-hot");
    property p_phase_per; phaseEn[0] |-> ##12 phaseEn[0]; endproperty
    a_phase_per: assert property (p_phase_per) else $error("phase period wrong");
    property p_tag_src;
        tag_ram_addr == (watcherTagAccess ? watcher_tag_addr[15:5] : cache_index_bus[15:5]);
    endproperty
    a_tag_src: assert property (p_tag_src) else $error("tag address source");
    property p_xidx; xlate_index_bus[15:13] == cache_index_bus[15:13]; endproperty
    a_xidx: assert property (p_xidx) else $error("index bits 15:13");
    property p_idrom; idRomAddr == watcher_tag_addr && idRomSel == idRomAccess; endproperty
    a_idrom: assert property (p_idrom) else $error("id rom address");
    property p_route;
        route.checkByte == ctrl_data_bus[8:0] && route.irqInfo == ctrl_data_bus[15:0];
    endproperty
    a_route: assert property (p_route) else $error("data routing");
    property p_decode; route.irqDecode == ctrl_addr_bus[7:0]; endproperty
    a_decode: assert property (p_decode) else $error("decode address");
    property p_diag;
        ctrlDataOe == diagRd && (!diagRd || ctrlDataDrive == {24'h000000, diagRdData});
    endproperty
    a_diag: assert property (p_diag) else $error("diag drive");
    property p_launch; launchStatus == latched_space_id[5:3]; endproperty
    a_launch: assert property (p_launch) else $error("launch status");
    property p_vhit;
        virtHitEn == {latched_space_id[1] & ~latched_space_id[4],
                      ~latched_space_id[1] & ~latched_space_id[5]};
    endproperty
    a_vhit: assert property (p_vhit) else $error("virtual hit enables");
    property p_asi;
        $changed(latched_space_id) |-> phaseEn[1] && $past(holdLoad && procReq.valid)
            && latched_space_id == $past(procReq.asi);
    endproperty
    a_asi: assert property (p_asi) else $error("space id latch");
    property p_low; phys_addr_bus[12:0] == cache_index_bus[12:0]; endproperty
    a_low: assert property (p_low) else $error("low address bits");
    property p_fill; fillValid && fillReady |=> !fillReady [*4]; endproperty
    a_fill: assert property (p_fill) else $error("fill spacing");
endmodule : cbd_datapath_chk

bind cbd_datapath cbd_datapath_chk u_cbd_datapath_chk (.*);

// ---- tb/cbd_tag_ram_model.sv ----
`timescale 1ns/1ps
module cbd_tag_ram_model (
    // clock
    input wire logic ref_clk,
    // physical tag store
    input wire logic [cbd_pkg::TAG_W-1:0] tag_ram_addr,
    input wire logic wrEn,
    input wire logic [cbd_pkg::TAG_W-1:0] wrAddr,
    input wire logic [cbd_pkg::PAGE_W-1:0] wrTag,
    output logic [cbd_pkg::PAGE_W-1:0] storedPhysTag,
    // diagnostic store
    input wire logic [cbd_pkg::ADDR_W-1:0] ctrl_addr_bus,
    input wire logic diagRd,
    output logic [cbd_pkg::DIAG_W-1:0] diagRdData
);
    import cbd_pkg::*;
    logic [PAGE_W-1:0] mem [2**TAG_W];
    logic [DIAG_W-1:0] idlePat = 8'h00;
    // unwritten entries never equal a real frame by accident
    initial begin
        for (int i = 0; i < 2**TAG_W; i++) mem[i] = ~PAGE_W'(i);
    end
    always @(posedge ref_clk) begin
        if (wrEn) mem[wrAddr] <= wrTag;
        idlePat <= idlePat + 8'h01;
    end
    assign storedPhysTag = mem[tag_ram_addr];
    // released lines show a moving pattern so stale data cannot pass
    assign diagRdData = diagRd ? ~ctrl_addr_bus[7:0] : idlePat;
endmodule : cbd_tag_ram_model

// ---- tb/cbd_datapath_tb.sv ----
`timescale 1ns/1ps
module cbd_datapath_tb;
    import cbd_pkg::*;
    localparam logic [ADDR_W-1:0] ADR_A = 32'h0ABC_D5A4;
    localparam logic [ASI_W-1:0] ASI_A = 8'h0B;
    localparam logic [PAGE_W-1:0] FRM_A = 19'h5A5A3;
    localparam logic [CIDX_W-1:0] WTA = 16'hB7E0;
    localparam logic [ADDR_W-1:0] CDB = 32'hA5C3_5F69;
    logic ref_clk, rstn, holdLoad, procFault, xlateMiss, procRdValid, walkLoad, dirBaseWr;
    logic phys_tag_match, watcherTagAccess, idRomAccess, idRomSel, fillValid, fillReady;
    logic diagRd, ctrlDataOe, tagWr, gotFault, gotRdValid;
    cbd_req_s procReq;
    cbd_line_s fillLine;
    cbd_route_s route;
    logic [2:0] walkFlags, launchStatus;
    logic [1:0] virtHitEn;
    logic [9:0] walkIndex;
    logic [PAGE_W-1:0] walkFrame, storedPhysTag, tagWrData;
    logic [ADDR_W-1:0] dirBaseData, dirBase, phys_addr_bus, xlate_index_bus, ctrl_addr_bus;
    logic [ADDR_W-1:0] ctrl_data_bus, ctrlDataDrive;
    logic [HALF_W-1:0] procRdData, gotRdData;
    logic [CIDX_W-1:0] cache_index_bus, watcher_tag_addr, idRomAddr;
    logic [TAG_W-1:0] tag_ram_addr, tagWrAddr;
    logic [ASI_W-1:0] latched_space_id;
    logic [DIAG_W-1:0] diagRdData;
    logic [PHASES-1:0] phaseEn;
    int n_mismatch = 0;
    int total_checks = 0;

    cbd_datapath #(.XLATE_IDX_W(10)) u_cbd_datapath (.ref_clk, .rstn, .procReq, .holdLoad,
        .procFault, .xlateMiss, .procRdData, .procRdValid, .walkLoad, .walkFrame, .walkFlags,
        .dirBaseWr, .dirBaseData, .dirBase, .walkIndex, .phys_addr_bus, .cache_index_bus,
        .xlate_index_bus, .tag_ram_addr, .ctrl_addr_bus, .latched_space_id, .storedPhysTag,
        .phys_tag_match, .virtHitEn, .launchStatus, .watcherTagAccess, .idRomAccess,
        .watcher_tag_addr, .idRomAddr, .idRomSel, .fillLine, .fillValid, .fillReady,
        .ctrl_data_bus, .diagRdData, .diagRd, .ctrlDataDrive, .ctrlDataOe, .route, .phaseEn);
    cbd_tag_ram_model u_cbd_tag_ram_model (.ref_clk, .tag_ram_addr, .wrEn(tagWr),
        .wrAddr(tagWrAddr), .wrTag(tagWrData), .storedPhysTag, .ctrl_addr_bus, .diagRd,
        .diagRdData);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // held until a phase 0 edge takes it; fault seen at c1, read data at c2
    task automatic access(input logic [ADDR_W-1:0] a, input logic [ASI_W-1:0] s, input logic w);
        int n = 0;
        procReq = '{addr: a, asi: s, valid: 1'b1, write: w};
        holdLoad = 1'b1;
        while (phaseEn[0] !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        cyc(1);
        procReq.valid = 1'b0;
        holdLoad = 1'b0;
        cyc(1);
        gotFault = procFault;
        cyc(1);
        gotRdValid = procRdValid;
        gotRdData = procRdData;
    endtask : access
    task automatic tag_wr(input logic [TAG_W-1:0] a, input logic [PAGE_W-1:0] t);
        tagWrAddr = a;
        tagWrData = t;
        tagWr = 1'b1;
        cyc(1);
        tagWr = 1'b0;
    endtask : tag_wr
    task automatic miss_load(input logic [ADDR_W-1:0] a, input logic [ASI_W-1:0] s,
                             input logic [2:0] flags);
        access(a, s, 1'b0);
        chk(xlateMiss, 1'b1);
        chk(walkIndex, {s[1], a[21:13]});
        walkFrame = FRM_A;
        walkFlags = flags;
        walkLoad = 1'b1;
        cyc(1);
        walkLoad = 1'b0;
        cyc(1);
        chk(walkIndex, 10'({s[1], a[21:13]} + 10'h001));
    endtask : miss_load

    task automatic t_miss_hit();
        dirBaseData = 32'h0012_3000;
        dirBaseWr = 1'b1;
        cyc(1);
        dirBaseWr = 1'b0;
        cyc(1);
        chk(dirBase, 32'h0012_3000);
        miss_load(ADR_A, ASI_A, 3'b111);
        chk(latched_space_id, ASI_A);
        chk(launchStatus, ASI_A[5:3]);
        chk(virtHitEn, {ASI_A[1] & ~ASI_A[4], ~ASI_A[1] & ~ASI_A[5]});
        chk(cache_index_bus, ADR_A[15:0]);
        chk(xlate_index_bus[31:13], ADR_A[31:13]);
        tag_wr(ADR_A[15:5], FRM_A);
        access(ADR_A, ASI_A, 1'b0);
        chk(xlateMiss, 1'b0);
        chk(phys_addr_bus, {FRM_A, ADR_A[12:0]});
        chk(ctrl_addr_bus, {FRM_A, ADR_A[12:0]});
        chk(phys_tag_match, 1'b1);
        chk(gotFault, 1'b0);
    endtask : t_miss_hit
    task automatic t_route();
        {watcherTagAccess, idRomAccess, diagRd} = 3'h7;
        watcher_tag_addr = WTA;
        ctrl_data_bus = CDB;
        cyc(1);
        chk(tag_ram_addr, WTA[15:5]);
        chk(idRomAddr, WTA);
        chk({ctrlDataOe, idRomSel}, 2'b11);
        chk(route.checkByte, CDB[8:0]);
        chk(route.irqInfo, CDB[15:0]);
        chk({route.irqDecode, route.diagAddr}, {2{ADR_A[7:0]}});
        chk(ctrlDataDrive, {24'h000000, ~ADR_A[7:0]});
        {watcherTagAccess, idRomAccess, diagRd} = 3'h0;
        cyc(1);
        chk(tag_ram_addr, ADR_A[15:5]);
        chk({ctrlDataOe, idRomSel}, 2'b00);
    endtask : t_route
    task automatic t_fill_read();
        int n = 0;
        fillLine = '{high: 32'hC0DE_0001, low: 32'h0BAD_0002};
        fillValid = 1'b1;
        cyc(1);
        fillValid = 1'b0;
        while (fillReady !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk(n, FILL_CYC - 1);
        access(ADR_A, ASI_A, 1'b0);
        chk(gotRdValid, 1'b1);
        chk(gotRdData, 32'hC0DE_0001);
        access(ADR_A & 32'hFFFF_FFFB, ASI_A, 1'b0);
        chk(gotRdData, 32'h0BAD_0002);
    endtask : t_fill_read
    task automatic t_faults();
        miss_load(ADR_A ^ 32'h0000_2000, ASI_A, 3'b101);
        access(ADR_A ^ 32'h0000_2000, ASI_A, 1'b1);
        chk(gotFault, 1'b1);
        miss_load(ADR_A ^ 32'h0000_4000, 8'h0A, 3'b011);
        access(ADR_A ^ 32'h0000_4000, 8'h0A, 1'b0);
        chk(gotFault, 1'b1);
    endtask : t_faults
    task automatic t_no_hold();
        procReq = '{addr: 32'h7777_0000, asi: 8'h3C, valid: 1'b1, write: 1'b0};
        cyc(14);
        procReq.valid = 1'b0;
        chk(latched_space_id, 8'h0A);
        tag_wr(ADR_A[15:5], FRM_A ^ 19'h00001);
        access(ADR_A, ASI_A, 1'b0);
        chk(phys_tag_match, 1'b0);
    endtask : t_no_hold

    initial begin
        rstn = 1'b0;
        procReq = '{addr: ADDR_RST, asi: ASI_RST, valid: 1'b0, write: 1'b0};
        {holdLoad, walkLoad, dirBaseWr, watcherTagAccess, idRomAccess, fillValid} = '0;
        {diagRd, tagWr, walkFrame, walkFlags, dirBaseData, watcher_tag_addr} = '0;
        {ctrl_data_bus, fillLine, tagWrAddr, tagWrData} = '0;
        repeat (6) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        chk({latched_space_id, ctrl_addr_bus}, {ASI_RST, ADDR_RST});
        chk(dirBase, ADDR_RST);
        t_miss_hit();
        t_route();
        t_fill_read();
        t_faults();
        t_no_hold();
        summarize();
    end
    // run is well under a thousand cycles
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule : cbd_datapath_tb
